/* File: verilog/dpm_pkg.sv */
// constants and carrier types for the dual-port memory block
`default_nettype none
package dpm_pkg;
  localparam int          LINES      = 512;
  localparam int          LINE_W     = 72;
  localparam int          DATA_W     = 64;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_AFULL  = 4'h4;
  localparam logic [3:0]  OFS_AEMPTY = 4'h8;
  localparam logic [3:0]  OFS_STATUS = 4'hc;
  localparam logic [31:0] CTRL_RST   = 32'h0000_2d00;
  localparam logic [31:0] CTRL_MASK  = 32'h0003_ffff;
  localparam logic [15:0] AFULL_RST  = 16'h7c00;
  localparam logic [15:0] AEMPTY_RST = 16'h0400;
  localparam logic [15:0] CAP_FULL   = 16'h8000;
  localparam logic [15:0] CAP_HALF   = 16'h4000;
  localparam logic [2:0]  W_MAX_FULL = 3'h5;
  localparam logic [2:0]  W_MAX_HALF = 3'h4;
  localparam logic [2:0]  W_MAX_WIDE = 3'h6;
  localparam logic [2:0]  W_PAR_MIN  = 3'h3;

  typedef enum logic [1:0] {
    WM_WRITE_FIRST = 2'b00,
    WM_READ_FIRST  = 2'b01,
    WM_NO_CHANGE   = 2'b10
  } dpm_wmode_t;

  typedef struct packed {
    logic [13:0] rsvd;
    dpm_wmode_t  wmode_b;
    dpm_wmode_t  wmode_a;
    logic [2:0]  width_b;
    logic [2:0]  width_a;
    logic        casc_sel;
    logic        latch_off;
    logic        outreg_b;
    logic        outreg_a;
    logic        ecc_en;
    logic        fifo_mode;
    logic        half_mode;
    logic        split_read_write_mode;
  } dpm_ctrl_t;

  typedef struct packed {
    logic [7:0]  par;
    logic [63:0] data;
  } dpm_word_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic [14:0] addr;
    dpm_word_t   wdata;
  } dpm_req_t;

  typedef logic [LINE_W-1:0] dpm_line_t;
endpackage : dpm_pkg
`default_nettype wire

/* File: verilog/dpm_secded.sv */
// hamming encoder and single-correct double-detect decoder for 64-bit words
`timescale 1ns/1ps
`default_nettype none
module dpm_secded
  import dpm_pkg::*;
(
  // encoder
  input  wire logic [63:0] enc_data_in,
  output logic      [7:0]  enc_chk_out,
  // decoder
  input  wire logic [63:0] dec_data_in,
  input  wire logic [7:0]  dec_chk_in,
  output logic      [63:0] dec_data_out,
  output logic             dec_sbit_out,
  output logic             dec_dbit_out
);
  // data bits fill the non power-of-two code positions 3..71
  function automatic logic [71:1] spread(input logic [63:0] d);
    int k;
    logic [71:1] cw;
    k = 0;
    cw = '0;
    for (int i = 1; i < 72; i++)
      if ((i & (i - 1)) != 0)
      begin
        cw[i] = d[k];
        k++;
      end
    return cw;
  endfunction : spread

  function automatic logic [63:0] gather(input logic [71:1] cw);
    int k;
    logic [63:0] d;
    k = 0;
    d = '0;
    for (int i = 1; i < 72; i++)
      if ((i & (i - 1)) != 0)
      begin
        d[k] = cw[i];
        k++;
      end
    return d;
  endfunction : gather

  function automatic logic [6:0] syndrome(input logic [71:1] cw);
    logic [6:0] s;
    s = '0;
    for (int i = 1; i < 72; i++)
      if (cw[i])
        s = s ^ 7'(i);
    return s;
  endfunction : syndrome

  logic [6:0]  enc_syn;
  logic [71:1] dec_cw;
  logic [71:1] fix_cw;
  logic [6:0]  dec_syn;
  logic        ovr_bad;

  assign enc_syn     = syndrome(spread(enc_data_in));
  assign enc_chk_out = {^enc_data_in ^ ^enc_syn, enc_syn};

  always_comb
  begin
    dec_cw = spread(dec_data_in);
    for (int b = 0; b < 7; b++)
      dec_cw[1 << b] = dec_chk_in[b];
  end

  assign dec_syn = syndrome(dec_cw);
  assign ovr_bad = ^dec_data_in ^ ^dec_chk_in;

  // odd overall parity means one flipped bit, which the syndrome locates
  always_comb
  begin
    fix_cw = dec_cw;
    if (ovr_bad && dec_syn != 7'h00 && dec_syn < 7'd72)
      fix_cw[dec_syn] = ~dec_cw[dec_syn];
  end

  assign dec_data_out = gather(fix_cw);
  assign dec_sbit_out = ovr_bad;
  assign dec_dbit_out = ~ovr_bad && (dec_syn != 7'h00);
endmodule : dpm_secded
`default_nettype wire

/* File: verilog/dpm_ram.sv */
// dual-port memory block with width shaping, split mode, ecc and fifo control
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dpm_ram
  import dpm_pkg::*;
(
  // clock, reset, gating
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic        sleep_in,
  // configuration port
  input  wire logic [3:0]  cfg_addr_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  output logic      [31:0] cfg_rdata_out,
  // port a
  input  wire dpm_req_t    a_req_in,
  output dpm_word_t        a_rd_out,
  // port b
  input  wire dpm_req_t    b_req_in,
  output dpm_word_t        b_rd_out,
  output logic             b_sbit_out,
  output logic             b_dbit_out,
  // cascade
  input  wire dpm_word_t   casc_rd_in,
  output dpm_word_t        casc_rd_out,
  // fifo flags
  output logic             fifo_full_out,
  output logic             fifo_empty_out,
  output logic             fifo_afull_out,
  output logic             fifo_aempty_out,
  // stand-alone codec
  input  wire logic [63:0] ext_enc_data_in,
  output logic      [7:0]  ext_enc_chk_out,
  input  wire dpm_word_t   ext_dec_in,
  output logic      [63:0] ext_dec_out,
  output logic             ext_sbit_out,
  output logic             ext_dbit_out
);
  // mask-merge one port word into a line; 9-bit lanes keep parity in bit 8
  function automatic dpm_line_t wr_merge(input dpm_line_t old, input dpm_word_t w,
                                         input logic [2:0] c, input logic [5:0] db);
    int dw;
    dpm_line_t r;
    dw = 1 << c;
    r = old;
    for (int j = 0; j < DATA_W; j++)
      if (j >= db && j < db + dw)
        r[(j / 8) * 9 + j % 8] = w.data[j - db];
    if (c >= W_PAR_MIN)
      for (int u = 0; u < 8; u++)
        if (u >= db / 8 && u < (db + dw) / 8)
          r[u * 9 + 8] = w.par[u - db / 8];
    return r;
  endfunction : wr_merge

  function automatic dpm_word_t rd_pick(input dpm_line_t l, input logic [2:0] c,
                                        input logic [5:0] db);
    int dw;
    dpm_word_t r;
    dw = 1 << c;
    r = '0;
    for (int j = 0; j < DATA_W; j++)
      if (j < dw && db + j < DATA_W)
        r.data[j] = l[((db + j) / 8) * 9 + (db + j) % 8];
    if (c >= W_PAR_MIN)
      for (int u = 0; u < 8; u++)
        if (u < dw / 8 && db / 8 + u < 8)
          r.par[u] = l[(db / 8 + u) * 9 + 8];
    return r;
  endfunction : rd_pick

  // single shared array, 512 lines of 72 bits
  dpm_line_t mem [LINES];

  dpm_ctrl_t   ctrl_r;
  logic [15:0] afull_r;
  logic [15:0] aempty_r;
  logic        sbit_seen_r;
  logic        dbit_seen_r;
  logic [31:0] cfg_rdata_r;
  logic [15:0] count_r;
  logic [14:0] wptr_r;
  logic [14:0] rptr_r;
  logic [15:0] cap;
  logic [15:0] dw_a;
  logic [15:0] dw_b;
  logic        push_ok;
  logic        pop_ok;
  logic        ctrl_wr;
  logic        stat_wr;
  logic [2:0]  lim;
  logic        ecc_on;
  logic [7:0]  enc_chk;
  logic [63:0] dec_data;
  logic        dec_sbit;
  logic        dec_dbit;
  logic        b_rd_now;
  logic [1:0]  flag_r;
  logic [1:0]  flag_out_r;

  dpm_req_t    req_in  [2];
  dpm_req_t    q_r     [2];
  dpm_req_t    q_nxt   [2];
  logic [2:0]  code    [2];
  logic [14:0] off     [2];
  logic [8:0]  ln      [2];
  logic [5:0]  db      [2];
  dpm_line_t   old_l   [2];
  dpm_line_t   new_l   [2];
  dpm_word_t   wword   [2];
  dpm_word_t   pick    [2];
  dpm_word_t   rd_r    [2];
  dpm_word_t   rd_nxt  [2];
  dpm_word_t   out_r   [2];
  dpm_word_t   fin     [2];

  assign req_in[0] = a_req_in;
  assign req_in[1] = b_req_in;

  // configuration decode
  assign ctrl_wr = cfg_wr_in && cfg_addr_in == OFS_CTRL;
  assign stat_wr = cfg_wr_in && cfg_addr_in == OFS_STATUS;

  // widths above the port limit only in split mode
  assign lim = ctrl_r.split_read_write_mode ? (ctrl_r.half_mode ? W_MAX_FULL : W_MAX_WIDE)
                                            : (ctrl_r.half_mode ? W_MAX_HALF : W_MAX_FULL);
  // requested shapes clamp to the legal limit
  assign code[0] = (ctrl_r.width_a > lim) ? lim : ctrl_r.width_a;
  // split mode pins the read side at the split limit: the wide width, or the full width in half mode
  assign code[1] = ctrl_r.split_read_write_mode ? lim
                 : ((ctrl_r.width_b > lim) ? lim : ctrl_r.width_b);
  assign dw_a = 16'(16'h0001 << code[0]);
  assign dw_b = 16'(16'h0001 << code[1]);

  // check bits only on full-block 64-bit split-mode words
  assign ecc_on = ctrl_r.ecc_en && ctrl_r.split_read_write_mode && !ctrl_r.half_mode
               && code[0] == W_MAX_WIDE;

  // fifo occupancy kept in data bits so unequal port widths share one count
  assign cap             = ctrl_r.half_mode ? CAP_HALF : CAP_FULL;
  // four status flags from the occupancy
  assign fifo_full_out   = (cap - count_r) < dw_a;
  assign fifo_empty_out  = count_r < dw_b;
  assign fifo_afull_out  = count_r >= afull_r;
  assign fifo_aempty_out = count_r <= aempty_r;
  // refused push or pop leaves pointers and data alone
  assign push_ok = ctrl_r.fifo_mode && a_req_in.en && !fifo_full_out && !sleep_in;
  assign pop_ok  = ctrl_r.fifo_mode && b_req_in.en && !fifo_empty_out && !sleep_in;

  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      count_r <= '0;
      wptr_r  <= '0;
      rptr_r  <= '0;
    end
    else if (ce_in)
    begin
      if (ctrl_wr)
      begin
        count_r <= '0;
        wptr_r  <= '0;
        rptr_r  <= '0;
      end
      else
      begin
        // each side steps by its own width
        count_r <= 16'(count_r + (push_ok ? dw_a : 16'h0000) - (pop_ok ? dw_b : 16'h0000));
        if (push_ok)
          wptr_r <= 15'((wptr_r + dw_a) & (cap - 16'h0001));
        if (pop_ok)
          rptr_r <= 15'((rptr_r + dw_b) & (cap - 16'h0001));
      end
    end

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    logic go;
    logic we_c;
    logic hsel;

    assign go   = ctrl_r.fifo_mode ? ((p == 0) ? push_ok : pop_ok)
                                   : (req_in[p].en && !sleep_in);
    assign we_c = (p == 0) ? (ctrl_r.fifo_mode || ctrl_r.split_read_write_mode || req_in[p].we)
                           : (!ctrl_r.fifo_mode && !ctrl_r.split_read_write_mode
                              && req_in[p].we);

    always_comb
    begin
      q_nxt[p].en    = go;
      q_nxt[p].we    = go && we_c;
      q_nxt[p].wdata = go ? req_in[p].wdata : q_r[p].wdata;
      // address kept between operations unless latching is off
      if (ctrl_r.fifo_mode)
        q_nxt[p].addr = 15'(((p == 0) ? wptr_r : rptr_r) >> code[p]);
      else if (go || ctrl_r.latch_off)
        q_nxt[p].addr = req_in[p].addr;
      else
        q_nxt[p].addr = q_r[p].addr;
    end

    // every request input captured on the clock
    always_ff @(posedge sys_clk_in or negedge rstn_in)
      if (!rstn_in)
        q_r[p] <= '0;
      else if (ce_in)
        q_r[p] <= q_nxt[p];

    // addresses scale by width, so any width reads any other
    assign off[p] = 15'(q_r[p].addr << code[p]);
    // split halves: each plain port owns one half
    assign hsel   = (p == 1) && ctrl_r.half_mode && !ctrl_r.fifo_mode
                 && !ctrl_r.split_read_write_mode;
    // half mode keeps each port inside 256 lines
    assign ln[p]  = ctrl_r.half_mode ? {hsel, off[p][13:6]} : off[p][14:6];
    assign db[p]  = off[p][5:0];

    assign old_l[p]       = mem[ln[p]];
    assign wword[p].data  = q_r[p].wdata.data;
    assign wword[p].par   = (p == 0 && ecc_on) ? enc_chk : q_r[p].wdata.par;
    assign new_l[p]       = wr_merge(old_l[p], wword[p], code[p], db[p]);
    assign pick[p]        = rd_pick(old_l[p], code[p], db[p]);

    // output during a write follows the port's write mode
    always_comb
    begin
      rd_nxt[p] = rd_r[p];
      if (q_r[p].en && q_r[p].we)
      begin
        case ((p == 0) ? ctrl_r.wmode_a : ctrl_r.wmode_b)
          WM_READ_FIRST: rd_nxt[p] = pick[p];
          WM_NO_CHANGE:  rd_nxt[p] = rd_r[p];
          default:       rd_nxt[p] = rd_pick(new_l[p], code[p], db[p]);
        endcase
      end
      else if (q_r[p].en)
      begin
        rd_nxt[p] = pick[p];
        // corrected word handed out in place of the raw one
        if (p == 1 && ecc_on)
          rd_nxt[p].data = dec_data;
      end
    end

    // read data registered on the edge
    always_ff @(posedge sys_clk_in or negedge rstn_in)
      if (!rstn_in)
      begin
        rd_r[p]  <= '0;
        out_r[p] <= '0;
      end
      else if (ce_in)
      begin
        rd_r[p]  <= rd_nxt[p];
        out_r[p] <= rd_r[p];
      end

    // pipeline register costs exactly one more cycle
    assign fin[p] = ((p == 0) ? ctrl_r.outreg_a : ctrl_r.outreg_b) ? out_r[p] : rd_r[p];
  end

  // same-line writes from both ports in one cycle: port b's line wins
  always_ff @(posedge sys_clk_in)
    if (ce_in)
      for (int p = 0; p < 2; p++)
        if (q_r[p].en && q_r[p].we)
          mem[ln[p]] <= new_l[p];

  // encoder on the write side, decoder on the read side
  dpm_secded u_ecc_mem (
    .enc_data_in  (q_r[0].wdata.data),
    .enc_chk_out  (enc_chk),
    .dec_data_in  (pick[1].data),
    .dec_chk_in   (pick[1].par),
    .dec_data_out (dec_data),
    .dec_sbit_out (dec_sbit),
    .dec_dbit_out (dec_dbit)
  );

  assign b_rd_now = q_r[1].en && !q_r[1].we && ecc_on;

  // error flags travel with the read word
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      flag_r     <= '0;
      flag_out_r <= '0;
    end
    else if (ce_in)
    begin
      if (q_r[1].en)
        flag_r <= b_rd_now ? {dec_dbit, dec_sbit} : 2'b00;
      flag_out_r <= flag_r;
    end

  assign a_rd_out    = fin[0];
  // cascade input replaces local data when selected
  assign b_rd_out    = ctrl_r.casc_sel ? casc_rd_in : fin[1];
  assign casc_rd_out = fin[1];
  assign b_sbit_out  = ctrl_r.outreg_b ? flag_out_r[0] : flag_r[0];
  assign b_dbit_out  = ctrl_r.outreg_b ? flag_out_r[1] : flag_r[1];

  // stand-alone codec for external wide memories
  logic [7:0]  ext_chk;
  logic [63:0] ext_dat;
  logic        ext_s;
  logic        ext_d;

  dpm_secded u_ecc_ext (
    .enc_data_in  (ext_enc_data_in),
    .enc_chk_out  (ext_chk),
    .dec_data_in  (ext_dec_in.data),
    .dec_chk_in   (ext_dec_in.par),
    .dec_data_out (ext_dat),
    .dec_sbit_out (ext_s),
    .dec_dbit_out (ext_d)
  );

  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      ext_enc_chk_out <= '0;
      ext_dec_out     <= '0;
      ext_sbit_out    <= 1'b0;
      ext_dbit_out    <= 1'b0;
    end
    else if (ce_in)
    begin
      ext_enc_chk_out <= ext_chk;
      ext_dec_out     <= ext_dat;
      ext_sbit_out    <= ext_s;
      ext_dbit_out    <= ext_d;
    end

  // configuration registers; sticky error bits clear by writing ones
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      ctrl_r      <= dpm_ctrl_t'(CTRL_RST);
      afull_r     <= AFULL_RST;
      aempty_r    <= AEMPTY_RST;
      sbit_seen_r <= 1'b0;
      dbit_seen_r <= 1'b0;
      cfg_rdata_r <= '0;
    end
    else if (ce_in)
    begin
      if (ctrl_wr)
        ctrl_r <= dpm_ctrl_t'(cfg_wdata_in & CTRL_MASK);
      if (cfg_wr_in && cfg_addr_in == OFS_AFULL)
        afull_r <= cfg_wdata_in[15:0];
      if (cfg_wr_in && cfg_addr_in == OFS_AEMPTY)
        aempty_r <= cfg_wdata_in[15:0];
      // a new error in the clearing cycle keeps its bit set
      sbit_seen_r <= (b_rd_now && dec_sbit) || (sbit_seen_r && !(stat_wr && cfg_wdata_in[4]));
      dbit_seen_r <= (b_rd_now && dec_dbit) || (dbit_seen_r && !(stat_wr && cfg_wdata_in[5]));
      if (!cfg_rd_in)
        cfg_rdata_r <= '0;
      else
        case (cfg_addr_in)
          OFS_CTRL:   cfg_rdata_r <= 32'(ctrl_r);
          OFS_AFULL:  cfg_rdata_r <= {16'h0000, afull_r};
          OFS_AEMPTY: cfg_rdata_r <= {16'h0000, aempty_r};
          OFS_STATUS: cfg_rdata_r <= {count_r, 10'h000, dbit_seen_r, sbit_seen_r,
                                      fifo_aempty_out, fifo_afull_out,
                                      fifo_empty_out, fifo_full_out};
          default:    cfg_rdata_r <= '0;
        endcase
    end

  assign cfg_rdata_out = cfg_rdata_r;
endmodule : dpm_ram
`default_nettype wire

/* File: sim/dpm_fab_model.sv */
// fabric user logic that gates port requests on the fifo flags
`timescale 1ns/1ps
`default_nettype none
module dpm_fab_model
  import dpm_pkg::*;
(
  // request wishes from the bench
  input  wire logic     polite_in,
  input  wire dpm_req_t a_want_in,
  input  wire dpm_req_t b_want_in,
  // flags seen by the fabric
  input  wire logic     full_in,
  input  wire logic     empty_in,
  // requests to the memory
  output var  dpm_req_t a_req_out,
  output var  dpm_req_t b_req_out
);
  // no push when full, no pop when empty, while polite_in is high
  always_comb
  begin
    a_req_out    = a_want_in;
    b_req_out    = b_want_in;
    a_req_out.en = a_want_in.en && !(polite_in && full_in);
    b_req_out.en = b_want_in.en && !(polite_in && empty_in);
  end
endmodule : dpm_fab_model
`default_nettype wire

/* File: sim/dpm_ram_asserts.sv */
// concurrent checks on the memory block ports
`timescale 1ns/1ps
`default_nettype none
module dpm_ram_chk
  import dpm_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  input wire logic        sleep_in,
  input wire logic [3:0]  cfg_addr_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic        cfg_wr_in,
  input wire logic        cfg_rd_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire dpm_req_t    a_req_in,
  input wire dpm_req_t    b_req_in,
  input wire dpm_word_t   a_rd_out,
  input wire dpm_word_t   b_rd_out,
  input wire dpm_word_t   casc_rd_in,
  input wire logic        fifo_full_out,
  input wire logic        fifo_empty_out,
  input wire logic        fifo_afull_out,
  input wire logic        fifo_aempty_out,
  input wire logic [63:0] ext_enc_data_in,
  input wire logic [7:0]  ext_enc_chk_out,
  input wire dpm_word_t   ext_dec_in,
  input wire logic [63:0] ext_dec_out,
  input wire logic        ext_sbit_out,
  input wire logic        ext_dbit_out
);
  logic       fifo_r;
  logic       casc_r;
  logic [3:0] flags;
  assign flags = {fifo_full_out, fifo_empty_out, fifo_afull_out, fifo_aempty_out};
  // shadow of mode bits, taken on the edge the design takes them
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fifo_r <= CTRL_RST[2];
      casc_r <= CTRL_RST[7];
    end
    else if (ce_in && cfg_wr_in && cfg_addr_in == OFS_CTRL)
    begin
      fifo_r <= cfg_wdata_in[2];
      casc_r <= cfg_wdata_in[7];
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  AST_RD_IDLE: assert property (ce_in && !cfg_rd_in |=> cfg_rdata_out == 32'h0)
    else $error("read data not cleared");
  AST_FLAG_EXCL: assert property (!(fifo_full_out && fifo_empty_out))
    else $error("full and empty together");
  AST_FULL_HOLD: assert property (fifo_r && fifo_full_out && !b_req_in.en && !cfg_wr_in
    |=> $stable(flags)) else $error("count moved while full");
  AST_EMPTY_HOLD: assert property (fifo_r && fifo_empty_out && !a_req_in.en && !cfg_wr_in
    |=> $stable(flags)) else $error("count moved while empty");
  AST_SLEEP_HOLD: assert property (fifo_r && sleep_in && !cfg_wr_in |=> $stable(flags))
    else $error("fifo moved while asleep");
  AST_CE_FREEZE: assert property (!ce_in && !casc_r
    |=> $stable(a_rd_out) && $stable(b_rd_out)) else $error("output moved with ce low");
  AST_CASC: assert property (casc_r |-> b_rd_out == casc_rd_in)
    else $error("cascade word not passed");
  AST_CODEC: assert property (ce_in && ext_dec_in == {ext_enc_chk_out, $past(ext_enc_data_in)}
    |=> !ext_sbit_out && !ext_dbit_out && ext_dec_out == $past(ext_enc_data_in, 2))
    else $error("clean codeword not passed");
endmodule : dpm_ram_chk
bind dpm_ram dpm_ram_chk dpm_ram_chk_i (.sys_clk_in, .rstn_in, .ce_in, .sleep_in,
  .cfg_addr_in, .cfg_wdata_in, .cfg_wr_in, .cfg_rd_in, .cfg_rdata_out, .a_req_in,
  .b_req_in, .a_rd_out, .b_rd_out, .casc_rd_in, .fifo_full_out, .fifo_empty_out,
  .fifo_afull_out, .fifo_aempty_out, .ext_enc_data_in, .ext_enc_chk_out, .ext_dec_in,
  .ext_dec_out, .ext_sbit_out, .ext_dbit_out);
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the dual-port memory block
`timescale 1ns/1ps
`default_nettype none
module tb
  import dpm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic        sleep = 1'b0;
  logic        polite = 1'b1;
  logic [3:0]  cfg_addr = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [63:0] enc_d = 64'h0;
  dpm_word_t   dec_w = '0;
  dpm_word_t   casc = '0;
  dpm_req_t    a_want = '0;
  dpm_req_t    b_want = '0;
  dpm_req_t    a_req, b_req;
  dpm_word_t   b_rd, a_rd, casc_o;
  logic [71:0] aw [2];
  bit          av [2];
  bit          rf;
  logic [31:0] rdata;
  logic        b_s, b_d, full, empty, afull, aempty, e_s, e_d;
  logic [7:0]  chk;
  logic [63:0] dec_o;
  logic [71:0] mem [int];
  logic [71:0] q [$];
  logic [71:0] pw [3];
  bit          pv [3];
  logic [71:0] mask, w;
  logic [15:0] lf = 16'h0036;
  // middle mode hands out the old word on a write
  logic [31:0] modes [3] = '{32'h3601, 32'h7621, 32'h3609};
  int          cnt, m, lat = 1, cyc, errors, n_tests;
  bit          fifo_on;

  always #50 clk = ~clk;

  dpm_fab_model dpm_fab_model_i (.polite_in(polite), .a_want_in(a_want), .b_want_in(b_want),
    .full_in(full), .empty_in(empty), .a_req_out(a_req), .b_req_out(b_req));
  dpm_ram dpm_ram_i (.sys_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .sleep_in(sleep),
    .cfg_addr_in(cfg_addr), .cfg_wdata_in(cfg_wdata), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
    .cfg_rdata_out(rdata), .a_req_in(a_req), .a_rd_out(a_rd), .b_req_in(b_req), .b_rd_out(b_rd),
    .b_sbit_out(b_s), .b_dbit_out(b_d), .casc_rd_in(casc), .casc_rd_out(casc_o),
    .fifo_full_out(full), .fifo_empty_out(empty), .fifo_afull_out(afull),
    .fifo_aempty_out(aempty), .ext_enc_data_in(enc_d), .ext_enc_chk_out(chk),
    .ext_dec_in(dec_w), .ext_dec_out(dec_o), .ext_sbit_out(e_s), .ext_dbit_out(e_d));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic rnd();
    repeat (5)
    begin
      lf = lfsr(lf);
      w = {w[55:0], lf};
    end
  endtask : rnd

  task automatic check(input logic [73:0] got, input logic [73:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("counts: errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(negedge clk);
    check(rdata, e);
  endtask : rd

  // a control write also empties the fifo
  task automatic set_ctrl(input logic [31:0] v);
    wr(OFS_CTRL, v);
    fifo_on = v[2];
    rf = v[15:14] == 2'b01;
    lat = v[5] ? 2 : 1;
    cnt = 0;
    q.delete();
  endtask : set_ctrl

  task automatic codec(input logic [63:0] flip, input logic [1:0] ef, input bit cd);
    rnd();
    @(posedge clk);
    enc_d <= w[63:0];
    repeat (2) @(posedge clk);
    dec_w <= {chk, w[63:0] ^ flip};
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({e_s, e_d, cd ? dec_o : 64'h0}, {ef, cd ? w[63:0] : 64'h0});
  endtask : codec

  // reference model: memory map, fifo queue and read pipeline
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
    casc <= {lf, lf, lf, lf, lf[7:0]};
    pv[2] = pv[1];
    pw[2] = pw[1];
    pv[1] = pv[0];
    pw[1] = pw[0];
    pv[0] = 1'b0;
    av[1] = av[0];
    aw[1] = aw[0];
    av[0] = 1'b0;
    m = cnt;
    if (rstn && ce && !sleep && fifo_on)
    begin
      if (a_req.en && 32768 - m >= 32)
      begin
        q.push_back(a_req.wdata);
        cnt += 32;
      end
      if (b_req.en && m >= 32)
      begin
        pv[0] = 1'b1;
        pw[0] = q.pop_front();
        cnt -= 32;
      end
    end
    else if (rstn && ce && !sleep)
    begin
      if (a_req.en)
      begin
        av[0] = !rf || mem.exists(a_req.addr);
        aw[0] = rf ? mem[a_req.addr] : a_req.wdata;
        mem[a_req.addr] = a_req.wdata;
      end
      if (b_req.en && mem.exists(b_req.addr))
      begin
        pv[0] = 1'b1;
        pw[0] = mem[b_req.addr];
      end
    end
  end

  always @(negedge clk)
  begin
    if (pv[lat])
    begin
      check(b_rd & mask, pw[lat] & mask);
      check({b_s, b_d}, 2'b00);
      check(casc_o & mask, pw[lat] & mask);
    end
    if (av[1] && !fifo_on)
      check(a_rd & mask, aw[1] & mask);
    if (fifo_on)
      check({full, empty, afull, aempty}, {(32768 - cnt) < 32, cnt < 32, cnt >= 31744, cnt <= 1024});
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_AFULL, {16'h0, AFULL_RST});
    rd(OFS_AEMPTY, {16'h0, AEMPTY_RST});
    rd(OFS_STATUS, 32'h0000_000a);
    rd(4'h2, 32'h0);
    set_ctrl(32'hffff_ffff);
    rd(OFS_CTRL, CTRL_MASK);
    @(negedge clk);
    check(b_rd, casc);
    $display("test registers done");
    for (int k = 0; k < 3; k++)
    begin
      set_ctrl(modes[k]);
      // stored check bits are not visible on the data side
      mask = k == 2 ? {8'h0, {64{1'b1}}} : '1;
      for (int i = 0; i < 8; i++)
      begin
        rnd();
        a_want <= '{1'b1, 1'b1, 15'(i * 37), w};
        @(posedge clk);
      end
      a_want.en <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        b_want <= '{1'b1, 1'b0, 15'(i * 37), 72'h0};
        sleep <= (i == 5);
        @(posedge clk);
      end
      b_want.en <= 1'b0;
      sleep <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      ce <= 1'b1;
      $display("test ram mode %0d done", k);
    end
    set_ctrl(32'h0000_2d04);
    mask = {8'h0f, 64'hffff_ffff};
    while (cnt < 32768)
    begin
      @(posedge clk);
      rnd();
      a_want <= '{1'b1, 1'b1, 15'h0, w};
      sleep <= w[1:0] == 2'b00;
      @(negedge clk);
    end
    @(posedge clk);
    polite <= 1'b0;
    sleep <= 1'b0;
    repeat (3) @(posedge clk);
    a_want.en <= 1'b0;
    polite <= 1'b1;
    rd(OFS_STATUS, 32'h8000_0005);
    while (cnt > 0)
    begin
      @(posedge clk);
      rnd();
      b_want <= '{1'b1, 1'b0, 15'h0, 72'h0};
      sleep <= w[1:0] == 2'b00;
      @(negedge clk);
    end
    @(posedge clk);
    polite <= 1'b0;
    sleep <= 1'b0;
    repeat (3) @(posedge clk);
    b_want.en <= 1'b0;
    polite <= 1'b1;
    rd(OFS_STATUS, 32'h0000_000a);
    $display("test fifo done");
    codec(64'h0, 2'b00, 1'b1);
    codec(64'h0000_0400_0000_0000, 2'b10, 1'b1);
    codec(64'h0000_0000_0000_0081, 2'b01, 1'b0);
    $display("test codec done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
